// *** hdl/lac_pkg.sv ***
package lac_pkg;

  // Lane and sample geometry
  localparam int LANES     = 16;
  localparam int SAMP_W    = 16;
  localparam int ADDR_W    = 16;
  localparam int DEPTH     = 65536;
  localparam int BW_LANES  = 8;

  // System clock
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;

  // Top sample rates of each format on the ADC side, in MHz
  localparam int BW_MAX_MHZ = 250;
  localparam int SW_MAX_MHZ = 500;
  localparam int TW_MAX_MHZ = 125;
  localparam int OW_MAX_MHZ = 65;

  // UART framing, 8N1
  localparam int          BAUD_RATE      = 115200;
  localparam logic [15:0] BAUD_DIV_RST   = 16'(CLK_HZ / BAUD_RATE - 1);
  localparam logic [3:0]  TX_SLOTS       = 4'ha;
  localparam logic [3:0]  RX_STOP_IDX    = 4'h9;
  localparam logic [3:0]  RX_START_IDX   = 4'h0;

  // Host command opcodes
  localparam logic [7:0] CMD_LEN  = 8'h01;
  localparam logic [7:0] CMD_CHAN = 8'h02;
  localparam logic [7:0] CMD_ARM  = 8'h03;
  localparam logic [7:0] CMD_READ = 8'h04;
  localparam logic [7:0] CMD_BAUD = 8'h05;
  localparam logic [7:0] CMD_HDR  = 8'h06;
  localparam logic [7:0] CMD_FMT  = 8'h07;

  // Format byte layout and resolution codes
  localparam int          FMT_SUB_BIT = 2;
  localparam logic [1:0]  RES_12      = 2'h0;
  localparam logic [1:0]  RES_14      = 2'h1;
  localparam logic [1:0]  RES_16      = 2'h2;
  localparam logic [15:0] MASK_12     = 16'h0fff;
  localparam logic [15:0] MASK_14     = 16'h3fff;
  localparam logic [15:0] MASK_16     = 16'hffff;

  // Reset values of the settings
  localparam logic [15:0] REC_LEN_RST = 16'hffff;
  localparam logic [1:0]  RES_RST     = RES_16;

endpackage

// *** hdl/lac_mem.sv ***
`timescale 1ns/1ps
module lac_mem
  import lac_pkg::*;
(
  input  wire logic                        clk,    // System clock
  input  wire logic                        we,     // Write strobe
  input  wire logic [lac_pkg::ADDR_W-1:0]  waddr,  // Write address
  input  wire logic [lac_pkg::SAMP_W-1:0]  wdata,  // Write data
  input  wire logic [lac_pkg::ADDR_W-1:0]  raddr,  // Read address
  output logic      [lac_pkg::SAMP_W-1:0]  rdata   // Read data, one cycle after raddr
);

  logic [SAMP_W-1:0] mem_r [DEPTH];

  // No reset so that the array maps onto block RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end

endmodule // lac_mem

// *** hdl/lac_top.sv ***
`timescale 1ns/1ps
module lac_top
  import lac_pkg::*;
#(
  parameter bit SERIAL_BUILD = 1'b0  // 1: serial formats, 0: parallel DDR formats
) (
  input  wire logic                       clk,        // System clock, 10 MHz
  input  wire logic                       arst_n,     // Configuration reset, returns every register and setting outside the capture memory to its reset value
  input  wire logic [lac_pkg::LANES-1:0]  lane_in,    // LVDS data lanes after receivers
  input  wire logic                       bclk_in,    // ADC bit clock or DDR data clock
  input  wire logic                       fclk_in,    // ADC frame clock, serial formats
  input  wire logic                       fifo_clr,   // Pushbutton, empties the capture buffer
  input  wire logic                       uart_rxd,   // UART from USB bridge
  output logic                            uart_txd,   // UART to USB bridge
  output logic      [lac_pkg::SAMP_W-1:0] samp_word,  // Rebuilt sample word
  output logic                            samp_clk,   // Toggles once per new sample
  output logic      [lac_pkg::SAMP_W-1:0] hdr_data,   // Header copy of the sample word
  output logic                            hdr_clk,    // Header copy of the sample clock
  output logic                            cap_busy,   // Capture in progress
  output logic                            rec_ready   // A full record is held
);

  typedef enum logic [1:0] {CMD_IDLE, CMD_HI, CMD_LO} lac_cmd_t;

  typedef struct packed {
    logic [LANES-1:0]          lane_s1;
    logic [LANES-1:0]          lane_s2;
    logic                      bclk_s1;
    logic                      bclk_s2;
    logic                      bclk_d;
    logic                      fclk_s1;
    logic                      fclk_s2;
    logic                      fclk_d;
    logic                      rx_s1;
    logic                      rx_s2;
    logic                      clr_s1;
    logic                      clr_s2;
    logic [BW_LANES-1:0]       odd_h;
    logic [SAMP_W-1:0]         sh;
    logic [SAMP_W-1:0]         samp;
    logic                      samp_vld;
    logic                      samp_clk;
    logic [SAMP_W-1:0]         hdr_data;
    logic                      hdr_clk;
    logic [ADDR_W-1:0]         rec_len;
    logic [3:0]                chan;
    logic [15:0]               baud_div;
    logic                      hdr_en;
    logic [1:0]                res;
    logic                      sub;
    logic                      cap_act;
    logic                      rec_ready;
    logic [ADDR_W-1:0]         wr_addr;
    logic                      rd_act;
    logic                      rd_pend;
    logic [ADDR_W-1:0]         rd_addr;
    logic [1:0][SAMP_W-1:0]    bufm;
    logic                      wp;
    logic                      rp;
    logic [1:0]                bcnt;
    logic [SAMP_W-1:0]         tw;
    logic                      tw_full;
    logic                      tw_lo;
    logic [8:0]                tx_sh;
    logic [3:0]                tx_cnt;
    logic [15:0]               tx_div;
    logic                      txd;
    logic                      rx_act;
    logic [15:0]               rx_div;
    logic [3:0]                rx_bit;
    logic [7:0]                rx_sh;
    lac_cmd_t                  cst;
    logic [7:0]                op;
    logic [7:0]                hi;
  } lac_st_t;

  lac_st_t            st_r;
  lac_st_t            st_nxt;
  logic [SAMP_W-1:0]  mem_rdata;
  logic               mem_we;
  logic               b_rise;
  logic               b_fall;
  logic               f_rise;
  logic               emit;
  logic [SAMP_W-1:0]  emit_val;
  logic [SAMP_W-1:0]  new_bits;
  logic               lane_a;
  logic               lane_b;
  logic               issue;
  logic               b_push;
  logic               b_pop;
  logic               rx_vld;
  logic [7:0]         tx_byte;

  function automatic logic [SAMP_W-1:0] res_mask(input logic [1:0] r);
    case (r)
      RES_12:  res_mask = MASK_12;
      RES_14:  res_mask = MASK_14;
      default: res_mask = MASK_16;
    endcase
  endfunction

  // Capture memory; written straight from the sample stream
  assign mem_we = st_r.samp_vld & st_r.cap_act;

  lac_mem u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (st_r.wr_addr),
    .wdata (st_r.samp),
    .raddr (st_r.rd_addr),
    .rdata (mem_rdata)
  );

  // Next-state logic for the whole block
  always_comb begin
    st_nxt   = st_r;
    emit     = 1'b0;
    emit_val = '0;
    new_bits = '0;
    lane_a   = 1'b0;
    lane_b   = 1'b0;
    rx_vld   = 1'b0;
    tx_byte  = '0;

    // Two-flop synchronisers for every pin except clk and arst_n
    st_nxt.lane_s1 = lane_in;
    st_nxt.lane_s2 = st_r.lane_s1;
    st_nxt.bclk_s1 = bclk_in;
    st_nxt.bclk_s2 = st_r.bclk_s1;
    st_nxt.bclk_d  = st_r.bclk_s2;
    st_nxt.fclk_s1 = fclk_in;
    st_nxt.fclk_s2 = st_r.fclk_s1;
    st_nxt.fclk_d  = st_r.fclk_s2;
    st_nxt.rx_s1   = uart_rxd;
    st_nxt.rx_s2   = st_r.rx_s1;
    st_nxt.clr_s1  = fifo_clr;
    st_nxt.clr_s2  = st_r.clr_s1;

    // Link clock edges; the sampled link must run at a quarter of clk or slower
    b_rise = st_r.bclk_s2 & ~st_r.bclk_d;
    b_fall = ~st_r.bclk_s2 & st_r.bclk_d;
    f_rise = st_r.fclk_s2 & ~st_r.fclk_d;

    // Deserialiser; only one family exists in a given build
    if (SERIAL_BUILD) begin
      // Shared bit and frame clocks serve whichever lane is selected
      if (st_r.sub) begin
        lane_a   = st_r.lane_s2[{st_r.chan[2:0], 1'b1}];
        lane_b   = st_r.lane_s2[{st_r.chan[2:0], 1'b0}];
        new_bits = {14'h0000, lane_a, lane_b};
      end else begin
        lane_a   = st_r.lane_s2[st_r.chan];
        new_bits = {15'h0000, lane_a};
      end
      if (f_rise) begin
        emit     = 1'b1;
        emit_val = st_r.sh;
        st_nxt.sh = (b_rise | b_fall) ? new_bits : '0;
      end else if (b_rise | b_fall) begin
        st_nxt.sh = st_r.sub ? {st_r.sh[SAMP_W-3:0], lane_a, lane_b} : {st_r.sh[SAMP_W-2:0], lane_a};
      end
    end else if (!st_r.sub) begin
      // Bit-wise DDR: odd bits on the rising edge, even bits on the falling edge
      if (b_rise) begin
        st_nxt.odd_h = st_r.lane_s2[BW_LANES-1:0];
      end
      if (b_fall) begin
        emit = 1'b1;
        for (int i = 0; i < BW_LANES; i++) begin
          emit_val[2*i+1] = st_r.odd_h[i];
          emit_val[2*i]   = st_r.lane_s2[i];
        end
      end
    end else if (b_rise | b_fall) begin
      emit     = 1'b1;
      emit_val = st_r.lane_s2;
    end

    // Parallel word and sample clock, mirrored to the header when enabled
    st_nxt.samp_vld = emit;
    if (emit) begin
      st_nxt.samp     = emit_val & res_mask(st_r.res);
      st_nxt.samp_clk = ~st_r.samp_clk;
    end
    st_nxt.hdr_data = st_r.hdr_en ? st_nxt.samp : '0;
    st_nxt.hdr_clk  = st_r.hdr_en & st_nxt.samp_clk;

    // UART receiver, sampling each bit mid-period
    if (!st_r.rx_act) begin
      if (!st_r.rx_s2) begin
        st_nxt.rx_act = 1'b1;
        st_nxt.rx_div = st_r.baud_div >> 1;
        st_nxt.rx_bit = RX_START_IDX;
      end
    end else if (st_r.rx_div != 16'h0000) begin
      st_nxt.rx_div = st_r.rx_div - 16'h0001;
    end else begin
      st_nxt.rx_div = st_r.baud_div;
      st_nxt.rx_bit = st_r.rx_bit + 4'h1;
      if (st_r.rx_bit == RX_START_IDX) begin
        st_nxt.rx_act = ~st_r.rx_s2;  // A glitch is not a start bit
      end else if (st_r.rx_bit == RX_STOP_IDX) begin
        st_nxt.rx_act = 1'b0;
        rx_vld        = st_r.rx_s2;   // Framing errors are dropped
      end else begin
        st_nxt.rx_sh = {st_r.rx_s2, st_r.rx_sh[7:1]};
      end
    end

    // Command parser writing the settings
    if (rx_vld) begin
      case (st_r.cst)
        CMD_IDLE: begin
          st_nxt.op = st_r.rx_sh;
          case (st_r.rx_sh)
            CMD_LEN, CMD_BAUD: st_nxt.cst = CMD_HI;
            CMD_CHAN, CMD_HDR, CMD_FMT: st_nxt.cst = CMD_LO;
            CMD_ARM: begin
              st_nxt.cap_act   = 1'b1;
              st_nxt.rec_ready = 1'b0;
              st_nxt.wr_addr   = '0;
            end
            CMD_READ: begin
              if (st_r.rec_ready && !st_r.rd_act) begin
                st_nxt.rd_act  = 1'b1;
                st_nxt.rd_addr = '0;
              end
            end
            default: st_nxt.cst = CMD_IDLE;
          endcase
        end
        CMD_HI: begin
          st_nxt.hi  = st_r.rx_sh;
          st_nxt.cst = CMD_LO;
        end
        CMD_LO: begin
          st_nxt.cst = CMD_IDLE;
          case (st_r.op)
            CMD_LEN:  st_nxt.rec_len  = {st_r.hi, st_r.rx_sh};
            CMD_BAUD: st_nxt.baud_div = {st_r.hi, st_r.rx_sh};
            CMD_CHAN: st_nxt.chan     = st_r.rx_sh[3:0];
            CMD_HDR:  st_nxt.hdr_en   = st_r.rx_sh[0];
            CMD_FMT: begin
              st_nxt.res = st_r.rx_sh[1:0];
              st_nxt.sub = st_r.rx_sh[FMT_SUB_BIT];
            end
            default: st_nxt.cst = CMD_IDLE;
          endcase
        end
        default: st_nxt.cst = CMD_IDLE;
      endcase
    end

    // Capture: consecutive samples from address zero; completion wins over a new arm
    if (mem_we) begin
      st_nxt.wr_addr = st_r.wr_addr + 16'h0001;
      if (st_r.wr_addr == st_r.rec_len) begin
        st_nxt.cap_act   = 1'b0;
        st_nxt.rec_ready = 1'b1;
      end
    end

    // Readout: a read is issued only if the two-entry buffer has room for it
    issue  = st_r.rd_act && ((st_r.bcnt == 2'h0) || (st_r.bcnt == 2'h1 && !st_r.rd_pend));
    b_push = st_r.rd_pend;
    b_pop  = (st_r.bcnt != 2'h0) && !st_r.tw_full;
    st_nxt.rd_pend = issue;
    if (issue) begin
      st_nxt.rd_addr = st_r.rd_addr + 16'h0001;
      if (st_r.rd_addr == st_r.rec_len) begin
        st_nxt.rd_act = 1'b0;
      end
    end
    if (b_push) begin
      st_nxt.bufm[st_r.wp] = mem_rdata;
      st_nxt.wp            = ~st_r.wp;
    end
    if (b_pop) begin
      st_nxt.tw      = st_r.bufm[st_r.rp];
      st_nxt.tw_full = 1'b1;
      st_nxt.tw_lo   = 1'b0;
      st_nxt.rp      = ~st_r.rp;
    end
    st_nxt.bcnt = st_r.bcnt + {1'b0, b_push} - {1'b0, b_pop};

    // UART transmitter, high byte of each sample first
    if (st_r.tx_cnt == 4'h0) begin
      if (st_r.tw_full) begin
        tx_byte        = st_r.tw_lo ? st_r.tw[7:0] : st_r.tw[15:8];
        st_nxt.txd     = 1'b0;
        st_nxt.tx_sh   = {1'b1, tx_byte};
        st_nxt.tx_cnt  = TX_SLOTS;
        st_nxt.tx_div  = st_r.baud_div;
        st_nxt.tw_lo   = ~st_r.tw_lo;
        st_nxt.tw_full = ~st_r.tw_lo;
      end
    end else if (st_r.tx_div != 16'h0000) begin
      st_nxt.tx_div = st_r.tx_div - 16'h0001;
    end else begin
      st_nxt.txd    = st_r.tx_sh[0];
      st_nxt.tx_sh  = {1'b1, st_r.tx_sh[8:1]};
      st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
      st_nxt.tx_div = st_r.baud_div;
    end

    // Pushbutton empties the record; settings and the byte on the wire survive
    if (st_r.clr_s2) begin
      st_nxt.cap_act   = 1'b0;
      st_nxt.rec_ready = 1'b0;
      st_nxt.rd_act    = 1'b0;
      st_nxt.rd_pend   = 1'b0;
      st_nxt.bcnt      = 2'h0;
      st_nxt.wp        = 1'b0;
      st_nxt.rp        = 1'b0;
      st_nxt.tw_full   = 1'b0;
      st_nxt.tw_lo     = 1'b0;
    end
  end

  // State register; header starts disabled in a parallel build
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r          <= '0;
      st_r.rx_s1    <= 1'b1;
      st_r.rx_s2    <= 1'b1;
      st_r.txd      <= 1'b1;
      st_r.baud_div <= BAUD_DIV_RST;
      st_r.rec_len  <= REC_LEN_RST;
      st_r.res      <= RES_RST;
      st_r.hdr_en   <= SERIAL_BUILD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign uart_txd  = st_r.txd;
  assign samp_word = st_r.samp;
  assign samp_clk  = st_r.samp_clk;
  assign hdr_data  = st_r.hdr_data;
  assign hdr_clk   = st_r.hdr_clk;
  assign cap_busy  = st_r.cap_act;
  assign rec_ready = st_r.rec_ready;

endmodule // lac_top

// *** dv/lac_adc_model.sv ***
`timescale 1ns/1ps
module lac_adc_model
  import lac_pkg::*;
(
  output logic [lac_pkg::LANES-1:0] lane_in,  // Data lanes toward the receiver
  output logic                      bclk_in,  // Data clock, still between samples
  output logic                      fclk_in   // Frame clock, unused by parallel formats
);
  localparam int HALF_NS = 400;  // Half period of the 800 ns link clock

  // Idle state at time zero
  initial begin
    lane_in = '0;
    bclk_in = 1'b0;
    fclk_in = 1'b0;
  end

  // Data settles a quarter period before the clock moves, so it sits mid eye
  // The inverse is shown a gap before the next word, so no lane changes twice at once
  task automatic drive_edge(input logic [LANES-1:0] v);
    lane_in = v;
    #(HALF_NS / 2);
    bclk_in = ~bclk_in;
    #(HALF_NS / 4);
    lane_in = ~v;  // Hold spent: show the inverse rather than stale data
    #(HALF_NS / 4);
  endtask

  // Bit-wise DDR: odd bits ride the rising edge, even bits the falling edge
  task automatic bit_wise(input logic [SAMP_W-1:0] s);
    logic [LANES-1:0] odd_w;
    logic [LANES-1:0] even_w;
    odd_w  = '0;
    even_w = '0;
    for (int i = 0; i < BW_LANES; i++) begin
      odd_w[i]  = s[2*i+1];
      even_w[i] = s[2*i];
    end
    drive_edge(odd_w);
    drive_edge(even_w);
  endtask

  // Sample-wise DDR: one whole sample per edge
  task automatic sample_wise(input logic [SAMP_W-1:0] s);
    drive_edge(LANES'(s));
  endtask
endmodule  // lac_adc_model

// *** dv/lac_top_properties.sv ***
`timescale 1ns/1ps
module lac_top_properties
  import lac_pkg::*;
(
  input wire logic                       clk,        // System clock
  input wire logic                       arst_n,     // Reset, active low
  input wire logic [lac_pkg::LANES-1:0]  lane_in,    // Data lanes
  input wire logic                       bclk_in,    // Link clock
  input wire logic                       fclk_in,    // Frame clock
  input wire logic                       fifo_clr,   // Buffer clear
  input wire logic                       uart_rxd,   // UART in
  input wire logic                       uart_txd,   // UART out
  input wire logic [lac_pkg::SAMP_W-1:0] samp_word,  // Sample word
  input wire logic                       samp_clk,   // Sample clock
  input wire logic [lac_pkg::SAMP_W-1:0] hdr_data,   // Header word
  input wire logic                       hdr_clk,    // Header clock
  input wire logic                       cap_busy,   // Capture running
  input wire logic                       rec_ready   // Record held
);
  logic bclk_d_r;
  logic bclk_edge;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Raw link clock one cycle back, so a new sample can be traced to a pin edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) bclk_d_r <= 1'b0;
    else bclk_d_r <= bclk_in;
  end
  assign bclk_edge = bclk_in ^ bclk_d_r;

  sequence link_edge_seen;
    $past(bclk_edge, 1) || $past(bclk_edge, 2) || $past(bclk_edge, 3);
  endsequence
  sequence clr_held;
    fifo_clr [*3];
  endsequence

  chk_sample_cause: assert property ($changed(samp_clk) |-> link_edge_seen)
    else $error("sample emitted without a link clock edge");
  chk_word_cause: assert property ($changed(samp_word) |-> $changed(samp_clk))
    else $error("sample word moved without its sample clock");
  chk_hdr_data: assert property ((hdr_data == samp_word) || (hdr_data == '0 && !hdr_clk))
    else $error("header word is neither a copy nor off");
  chk_hdr_clk: assert property ((hdr_clk == samp_clk) || (!hdr_clk && hdr_data == '0))
    else $error("header clock is neither a copy nor off");
  chk_ready_excl: assert property (!(rec_ready && cap_busy))
    else $error("record ready while capture still runs");
  chk_busy_done: assert property ($fell(cap_busy) |-> rec_ready || $past(fifo_clr, 2) || $past(fifo_clr, 3))
    else $error("capture ended without a full record");
  chk_ready_holds: assert property ($fell(rec_ready) |-> $rose(cap_busy) || $past(fifo_clr, 2) || $past(fifo_clr, 3))
    else $error("record dropped without arm or clear");
  chk_clr_empty: assert property (clr_held |=> !rec_ready && !cap_busy)
    else $error("clear left the buffer busy or full");
endmodule  // lac_top_properties

bind lac_top lac_top_properties u_props (
  .clk(clk), .arst_n(arst_n), .lane_in(lane_in), .bclk_in(bclk_in), .fclk_in(fclk_in),
  .fifo_clr(fifo_clr), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .samp_word(samp_word),
  .samp_clk(samp_clk), .hdr_data(hdr_data), .hdr_clk(hdr_clk), .cap_busy(cap_busy), .rec_ready(rec_ready)
);

// *** dv/lac_adc_capture_tb.sv ***
`timescale 1ns/1ps
module lac_adc_capture_tb;
  import lac_pkg::*;
  typedef struct packed {
    logic [7:0]  fmt;
    logic        hdr;
    logic [15:0] val;
    logic [15:0] exp;
  } lac_row_t;

  logic              clk, arst_n, bclk_in, fclk_in, fifo_clr, uart_rxd, uart_txd;
  logic              samp_clk, hdr_clk, cap_busy, rec_ready, old_clk, hdr_now, quiet;
  logic [LANES-1:0]  lane_in;
  logic [SAMP_W-1:0] samp_word, hdr_data;
  logic [7:0]        fmt_now, b_hi, b_lo;
  int                mismatches, tests_run, bt;
  // Format byte 0x02 is bit-wise 16 bit, 0x06 sample-wise 16 bit, 0x04 and 0x05 sample-wise 12 and 14 bit
  // The last row goes back to 16 bit, as the record below relies on full words
  lac_row_t rows [7] = '{'{8'h02, 1'b0, 16'ha5c3, 16'ha5c3}, '{8'h02, 1'b1, 16'h8001, 16'h8001},
                         '{8'h06, 1'b1, 16'hffff, 16'hffff}, '{8'h06, 1'b0, 16'h1234, 16'h1234},
                         '{8'h04, 1'b0, 16'hfabc, 16'h0abc}, '{8'h05, 1'b1, 16'hc321, 16'h0321},
                         '{8'h06, 1'b1, 16'h0000, 16'h0000}};

  lac_top #(.SERIAL_BUILD(1'b0)) u_dut (
    .clk(clk), .arst_n(arst_n), .lane_in(lane_in), .bclk_in(bclk_in), .fclk_in(fclk_in),
    .fifo_clr(fifo_clr), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .samp_word(samp_word),
    .samp_clk(samp_clk), .hdr_data(hdr_data), .hdr_clk(hdr_clk), .cap_busy(cap_busy), .rec_ready(rec_ready)
  );
  lac_adc_model u_adc (.lane_in(lane_in), .bclk_in(bclk_in), .fclk_in(fclk_in));

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      $display("wrong value at %0t: %s", $time, m);
      mismatches++;
    end
  endtask

  // 8N1 byte to the receiver, LSB first, bt clocks per bit
  task automatic tx_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      uart_rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (bt) @(negedge clk);
    end
  endtask

  // Waits for a start bit under a bound, then samples each bit mid way
  task automatic rx_byte(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'h00;
    while (uart_txd !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(n < 2000, "no start bit");
    repeat (bt / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(negedge clk);
      b[i] = uart_txd;
    end
    repeat (bt) @(negedge clk);
    check(uart_txd === 1'b1, "stop bit");
  endtask

  // One sample over the link, then a bounded wait for the sample clock to move
  task automatic put(input logic sw, input logic [15:0] v);
    int n;
    n = 0;
    old_clk = samp_clk;
    if (sw) u_adc.sample_wise(v);
    else u_adc.bit_wise(v);
    while (samp_clk === old_clk && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(n < 20, "no sample clock");
  endtask

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about 4000 clocks; two and a half times that means a hang
  initial begin
    #1_000_000;
    mismatches++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    fifo_clr = 1'b0;
    uart_rxd = 1'b1;
    bt = 87;
    mismatches = 0;
    tests_run = 0;
    repeat (16) @(negedge clk);
    check(uart_txd === 1'b1 && samp_word === '0 && hdr_data === '0 && rec_ready === 1'b0, "reset");
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    // Speed the host link up first, at the reset divider
    tx_byte(CMD_BAUD);
    tx_byte(8'h00);
    tx_byte(8'h03);
    bt = 4;
    fmt_now = 8'hff;
    hdr_now = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].fmt !== fmt_now) begin
        tx_byte(CMD_FMT);
        tx_byte(rows[i].fmt);
        fmt_now = rows[i].fmt;
      end
      if (rows[i].hdr !== hdr_now) begin
        tx_byte(CMD_HDR);
        tx_byte({7'h00, rows[i].hdr});
        hdr_now = rows[i].hdr;
      end
      put(rows[i].fmt[FMT_SUB_BIT], rows[i].val);
      check(samp_word === rows[i].exp, "sample word");
      check(hdr_data === (rows[i].hdr ? rows[i].exp : 16'h0000), "header copy");
      check(hdr_clk === (rows[i].hdr & samp_clk), "header clock");
    end
    // Record of four samples, read back in order
    tx_byte(CMD_LEN);
    tx_byte(8'h00);
    tx_byte(8'h03);
    tx_byte(CMD_ARM);
    repeat (2) @(negedge clk);
    check(cap_busy === 1'b1 && rec_ready === 1'b0, "armed");
    for (int k = 0; k < 4; k++) put(1'b1, 16'(16'h1111 * (k + 1)));
    repeat (3) @(negedge clk);
    check(rec_ready === 1'b1 && cap_busy === 1'b0, "record full");
    tx_byte(CMD_READ);
    for (int k = 0; k < 4; k++) begin
      rx_byte(b_hi);
      rx_byte(b_lo);
      check({b_hi, b_lo} === 16'(16'h1111 * (k + 1)), "record order");
    end
    // Clear empties the record but keeps baud and length
    fifo_clr = 1'b1;
    repeat (3) @(negedge clk);
    fifo_clr = 1'b0;
    repeat (3) @(negedge clk);
    check(rec_ready === 1'b0, "cleared");
    tx_byte(CMD_READ);
    quiet = 1'b1;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk);
      quiet = quiet & uart_txd;
    end
    check(quiet === 1'b1, "read after clear");
    tx_byte(CMD_ARM);
    for (int k = 0; k < 4; k++) put(1'b1, 16'(16'h0f0f + k));
    repeat (3) @(negedge clk);
    check(rec_ready === 1'b1, "length kept");
    print_verdict();
  end
endmodule  // lac_adc_capture_tb
